// ===== wds_pkg.sv
// Constants for the write channel default shim
package wds_pkg;
    // Bus widths of both ports, and the write-count width
    localparam int ADDR_W     = 32;
    localparam int MST_ADDR_W = 24;
    localparam int DATA_W     = 32;
    localparam int STRB_W     = 4;
    localparam int ID_W       = 4;
    localparam int LEN_W      = 8;
    localparam int SIZE_W     = 3;
    localparam int BURST_W    = 2;
    localparam int CACHE_W    = 4;
    localparam int PROT_W     = 3;
    localparam int RESP_W     = 2;
    localparam int PEND_W     = 4;

    // Values driven where the master leaves a signal out
    localparam logic [ID_W-1:0]    DEF_ID     = 4'h0;
    localparam logic [3:0]         DEF_REGION = 4'h0;
    localparam logic [3:0]         DEF_QOS    = 4'h0;
    localparam logic [LEN_W-1:0]   DEF_LEN    = 8'h00;
    localparam logic [SIZE_W-1:0]  DEF_SIZE   = 3'h2;
    localparam logic [BURST_W-1:0] DEF_BURST  = 2'h1;
    localparam logic               DEF_LOCK   = 1'h0;
    localparam logic [CACHE_W-1:0] DEF_CACHE  = 4'h0;
    localparam logic [STRB_W-1:0]  DEF_STRB   = 4'hf;
    localparam logic [ADDR_W-MST_ADDR_W-1:0] DEF_ADDR_HI = 8'h00;

    // Response codes
    localparam logic [RESP_W-1:0]  RESP_OKAY  = 2'h0;

    // Write-count limits and beat-count steps
    localparam logic [PEND_W-1:0]  PEND_ZERO  = 4'h0;
    localparam logic [PEND_W-1:0]  PEND_ONE   = 4'h1;
    localparam logic [PEND_W-1:0]  PEND_MAX   = 4'hf;
    localparam logic [LEN_W-1:0]   BEAT_ONE   = 8'h01;
    localparam logic [LEN_W-1:0]   BEAT_ZERO  = 8'h00;
endpackage

// ===== wds_beat_counter.sv
// Write-data beat counter that finds the last beat from the burst length
`timescale 1ns/1ps
module wds_beat_counter
    import wds_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             beat,
    input  wire logic [LEN_W-1:0] len,
    output logic                  is_last
);
    typedef struct packed {
        logic [LEN_W-1:0] count;
    } wds_beat_state_t;

    wds_beat_state_t st;
    wds_beat_state_t next_st;

    // Last beat when the count reaches the burst length
    assign is_last = (st.count == len);

    // Count beats and wrap at the end of each burst
    always_comb begin
        next_st = st;
        if (beat) begin
            if (is_last) begin
                next_st.count = BEAT_ZERO;
            end else begin
                next_st.count = st.count + BEAT_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st.count <= BEAT_ZERO;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== wds_shim.sv
// Write-only shim: reduced master port to full memory-slave port with defaults
`timescale 1ns/1ps
module wds_shim
    import wds_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    // Reduced master side
    input  wire logic [MST_ADDR_W-1:0] M_AWADDR,
    input  wire logic [PROT_W-1:0]     M_AWPROT,
    input  wire logic                  M_AWVALID,
    output logic                       M_AWREADY,
    input  wire logic [DATA_W-1:0]     M_WDATA,
    input  wire logic                  M_WLAST,
    input  wire logic                  M_WVALID,
    output logic                       M_WREADY,
    output logic                       M_BVALID,
    input  wire logic                  M_BREADY,
    // Full memory-slave side
    output logic [ID_W-1:0]            S_AWID,
    output logic [ADDR_W-1:0]          S_AWADDR,
    output logic [3:0]                 S_AWREGION,
    output logic [LEN_W-1:0]           S_AWLEN,
    output logic [SIZE_W-1:0]          S_AWSIZE,
    output logic [BURST_W-1:0]         S_AWBURST,
    output logic                       S_AWLOCK,
    output logic [CACHE_W-1:0]         S_AWCACHE,
    output logic [PROT_W-1:0]          S_AWPROT,
    output logic [3:0]                 S_AWQOS,
    output logic                       S_AWVALID,
    input  wire logic                  S_AWREADY,
    output logic [DATA_W-1:0]          S_WDATA,
    output logic [STRB_W-1:0]          S_WSTRB,
    output logic                       S_WLAST,
    output logic                       S_WVALID,
    input  wire logic                  S_WREADY,
    input  wire logic [ID_W-1:0]       S_BID,
    input  wire logic [RESP_W-1:0]     S_BRESP,
    input  wire logic                  S_BVALID,
    output logic                       S_BREADY,
    // Status
    output logic                       LAST_ERROR,
    output logic                       RESP_ERROR,
    output logic                       ORPHAN_RESP,
    output logic [PEND_W-1:0]          PENDING_WRITES
);
    typedef struct packed {
        logic [PEND_W-1:0] pending;
        logic              last_error;
        logic              resp_error;
        logic              orphan_resp;
    } wds_state_t;

    wds_state_t st;
    wds_state_t next_st;

    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic cnt_last;
    logic aw_room;

    // Stall new addresses only when the write count stands at PEND_MAX
    assign aw_room = (st.pending != PEND_MAX);

    // Defaults made locally; constants so they hold in the AWVALID cycle
    assign S_AWID     = DEF_ID;
    assign S_AWREGION = DEF_REGION;
    assign S_AWQOS    = DEF_QOS;
    assign S_AWLEN    = DEF_LEN;
    assign S_AWSIZE   = DEF_SIZE;
    assign S_AWBURST  = DEF_BURST;
    assign S_AWLOCK   = DEF_LOCK;
    assign S_AWCACHE  = DEF_CACHE;
    assign S_WSTRB    = DEF_STRB;

    // Narrow master address widened with zero high bits
    assign S_AWADDR = {DEF_ADDR_HI, M_AWADDR};

    // Mandatory signals pass through with no register stage
    assign S_AWPROT  = M_AWPROT;
    assign S_AWVALID = M_AWVALID && aw_room;
    assign M_AWREADY = S_AWREADY && aw_room;
    assign S_WDATA   = M_WDATA;
    assign S_WLAST   = M_WLAST;
    assign S_WVALID  = M_WVALID;
    assign M_WREADY  = S_WREADY;
    assign M_BVALID  = S_BVALID;
    // Response ID and code are dropped: the reduced master omits them
    assign S_BREADY  = M_BREADY;

    // Handshake events
    assign aw_fire = S_AWVALID && S_AWREADY;
    assign w_fire  = M_WVALID && S_WREADY;
    assign b_fire  = S_BVALID && M_BREADY;

    // Beat counting against the length the slave actually sees
    wds_beat_counter u_beats (
        .clk     (CLK),
        .resetn  (RESETN),
        .beat    (w_fire),
        .len     (S_AWLEN),
        .is_last (cnt_last)
    );

    // Bookkeeping: outstanding writes and sticky protocol flags
    always_comb begin
        next_st = st;
        // Count from address accept to response accept
        if (aw_fire && !b_fire) begin
            next_st.pending = st.pending + PEND_ONE;
        end else if (b_fire && !aw_fire && st.pending != PEND_ZERO) begin
            next_st.pending = st.pending - PEND_ONE;
        end
        // Master's marker disagreeing with the counted last beat
        if (w_fire && (M_WLAST != cnt_last)) begin
            next_st.last_error = 1'b1;
        end
        // Master cannot see errors, so record any non-OKAY code
        if (b_fire && (S_BRESP != RESP_OKAY)) begin
            next_st.resp_error = 1'b1;
        end
        // Response with no write outstanding is still accepted, never hung
        if (b_fire && st.pending == PEND_ZERO && !aw_fire) begin
            next_st.orphan_resp = 1'b1;
        end
    end

    // State register; flags stay until reset
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st.pending     <= PEND_ZERO;
            st.last_error  <= 1'b0;
            st.resp_error  <= 1'b0;
            st.orphan_resp <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Status outputs straight from flip-flops
    assign LAST_ERROR     = st.last_error;
    assign RESP_ERROR     = st.resp_error;
    assign ORPHAN_RESP    = st.orphan_resp;
    assign PENDING_WRITES = st.pending;

    // Checks on what the shim drives
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    property p_id_region_qos;
        S_AWVALID |-> (S_AWID == DEF_ID) && (S_AWREGION == DEF_REGION)
            && (S_AWQOS == DEF_QOS);
    endproperty
    a_id_region_qos: assert property (p_id_region_qos)
        else $error("defaulted id, region or qos not zero");

    property p_len_one_beat;
        S_AWVALID |-> (S_AWLEN == 8'h00);
    endproperty
    a_len_one_beat: assert property (p_len_one_beat)
        else $error("burst length not single transfer");

    property p_size_full;
        S_AWVALID |-> (S_AWSIZE == 3'h2);
    endproperty
    a_size_full: assert property (p_size_full)
        else $error("size is not the full bus width");

    property p_burst_incr;
        S_AWVALID |-> (S_AWBURST == 2'h1) && !S_AWLOCK && (S_AWCACHE == 4'h0);
    endproperty
    a_burst_incr: assert property (p_burst_incr)
        else $error("burst, lock or cache default wrong");

    property p_strb_all;
        S_WVALID |-> (S_WSTRB == 4'hf);
    endproperty
    a_strb_all: assert property (p_strb_all)
        else $error("strobes not all asserted");

    property p_addr_zero_ext;
        S_AWVALID |-> (S_AWADDR[ADDR_W-1:MST_ADDR_W] == 8'h00)
            && (S_AWADDR[MST_ADDR_W-1:0] == M_AWADDR);
    endproperty
    a_addr_zero_ext: assert property (p_addr_zero_ext)
        else $error("high address bits not zero or low bits altered");

    property p_same_cycle;
        (M_WVALID == S_WVALID) && (M_BVALID == S_BVALID) && (S_BREADY == M_BREADY)
            && (M_WREADY == S_WREADY) && (S_AWPROT == M_AWPROT);
    endproperty
    a_same_cycle: assert property (p_same_cycle)
        else $error("pass-through signal delayed or altered");

    property p_last_flag;
        (w_fire && !M_WLAST) |=> LAST_ERROR;
    endproperty
    a_last_flag: assert property (p_last_flag)
        else $error("missing final-beat marker not flagged");

    property p_pending_up;
        (aw_fire && !b_fire) |=> (PENDING_WRITES == $past(PENDING_WRITES) + 4'h1);
    endproperty
    a_pending_up: assert property (p_pending_up)
        else $error("write count did not rise on address accept");

    property p_resp_flag;
        (b_fire && S_BRESP != 2'h0) |=> RESP_ERROR [*2];
    endproperty
    a_resp_flag: assert property (p_resp_flag)
        else $error("error response not recorded");

    property p_aw_stall;
        (PENDING_WRITES == 4'hf) |-> !S_AWVALID && !M_AWREADY;
    endproperty
    a_aw_stall: assert property (p_aw_stall)
        else $error("address accepted with write count full");

    // Address valid gated only by the write-count limit
    property p_awvalid_gate;
        S_AWVALID == (M_AWVALID && (PENDING_WRITES != PEND_MAX));
    endproperty
    a_awvalid_gate: assert property (p_awvalid_gate)
        else $error("address valid not passed through");

    // Address ready returned in the same cycle
    property p_awready_gate;
        M_AWREADY == (S_AWREADY && (PENDING_WRITES != PEND_MAX));
    endproperty
    a_awready_gate: assert property (p_awready_gate)
        else $error("address ready not passed back");

    // Write data and marker reach the slave unchanged
    property p_wdata_pass;
        (S_WDATA == M_WDATA) && (S_WLAST == M_WLAST);
    endproperty
    a_wdata_pass: assert property (p_wdata_pass)
        else $error("write data or marker altered");

    // Accepted response lowers the count by one
    property p_pending_down;
        (b_fire && !aw_fire && (PENDING_WRITES != PEND_ZERO))
            |=> (PENDING_WRITES == $past(PENDING_WRITES) - PEND_ONE);
    endproperty
    a_pending_down: assert property (p_pending_down)
        else $error("write count did not fall on response accept");

    // No change when neither or both ends fire
    property p_pending_hold;
        (aw_fire == b_fire) |=> $stable(PENDING_WRITES);
    endproperty
    a_pending_hold: assert property (p_pending_hold)
        else $error("write count moved without a net event");

    // Orphan response is taken, count stays at its floor
    property p_pending_floor;
        (b_fire && !aw_fire && (PENDING_WRITES == PEND_ZERO))
            |=> (PENDING_WRITES == PEND_ZERO) && ORPHAN_RESP;
    endproperty
    a_pending_floor: assert property (p_pending_floor)
        else $error("orphan response not recorded or count wrapped");

    // Owed response never marks an orphan
    property p_orphan_quiet;
        (b_fire && (PENDING_WRITES != PEND_ZERO) && !ORPHAN_RESP) |=> !ORPHAN_RESP;
    endproperty
    a_orphan_quiet: assert property (p_orphan_quiet)
        else $error("owed response flagged as orphan");

    // Flags hold until reset; nothing else may clear them
    property p_last_sticky;
        LAST_ERROR |=> LAST_ERROR;
    endproperty
    a_last_sticky: assert property (p_last_sticky)
        else $error("marker flag dropped without reset");

    // Error record survives later clean responses
    property p_resp_sticky;
        RESP_ERROR |=> RESP_ERROR;
    endproperty
    a_resp_sticky: assert property (p_resp_sticky)
        else $error("response flag dropped without reset");

    // Orphan record survives later traffic
    property p_orphan_sticky;
        ORPHAN_RESP |=> ORPHAN_RESP;
    endproperty
    a_orphan_sticky: assert property (p_orphan_sticky)
        else $error("orphan flag dropped without reset");

    // Correct marker leaves the flag clear
    property p_last_clean;
        (w_fire && M_WLAST && !LAST_ERROR) |=> !LAST_ERROR;
    endproperty
    a_last_clean: assert property (p_last_clean)
        else $error("marker flag set on a correct last beat");

    // OKAY code leaves the flag clear
    property p_resp_clean;
        (b_fire && (S_BRESP == RESP_OKAY) && !RESP_ERROR) |=> !RESP_ERROR;
    endproperty
    a_resp_clean: assert property (p_resp_clean)
        else $error("response flag set on an OKAY code");

    // Length default is one transfer, so every beat ends its burst
    property p_beat_single;
        w_fire |-> cnt_last;
    endproperty
    a_beat_single: assert property (p_beat_single)
        else $error("beat count missed the end of a single-beat burst");

    // Reset must clear the state, so this check is never disabled
    property p_reset_clear;
        disable iff (1'b0)
        !RESETN |=> (PENDING_WRITES == PEND_ZERO) && !LAST_ERROR && !RESP_ERROR
            && !ORPHAN_RESP;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("status not cleared by reset");
endmodule

// ===== wds_slave_model.sv
// Partner model: memory slave on the full side of the shim
`timescale 1ns/1ps
module wds_slave_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic       wvalid,
    output logic            wready,
    output logic [3:0]      bid,
    output logic [1:0]      bresp,
    output logic            bvalid,
    input  wire logic       bready,
    input  wire logic       stall,
    input  wire logic       hold_b,
    input  wire logic       err,
    input  wire logic       orphan
);
    logic [3:0] aw_owed;
    logic [3:0] w_owed;
    logic       paired;
    logic       issue;
    // Ready follows stall only, so every request still ends in a handshake
    assign awready = !stall;
    assign wready  = !stall;
    // A response waits for both its address and its data beat
    assign paired  = (aw_owed != 4'h0) && (w_owed != 4'h0);
    assign issue   = !bvalid && !hold_b && (paired || orphan);
    // Response ID always driven; scrambled while no response stands
    assign bid     = bvalid ? 4'h0 : 4'hf;
    // One response per completed write; orphan forces one with none owed
    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_owed <= 4'h0;
            w_owed  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= 2'h3;
        end else begin
            aw_owed <= aw_owed + {3'h0, awvalid && awready} - {3'h0, issue && paired};
            w_owed  <= w_owed + {3'h0, wvalid && wready} - {3'h0, issue && paired};
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                bresp  <= ~bresp; // Released, so no stale code is left
            end else if (issue) begin
                bvalid <= 1'b1;
                bresp  <= err ? 2'h2 : 2'h0;
            end
        end
    end
endmodule

// ===== tb_write_channel_default_shim.sv
// Self-checking testbench of the write channel default shim
`timescale 1ns/1ps
module tb_write_channel_default_shim;
    import wds_pkg::*;
    logic CLK = 0, RESETN = 0, M_AWVALID = 0, M_WLAST = 0, M_WVALID = 0, M_BREADY = 1;
    logic [23:0] M_AWADDR = 0;
    logic [2:0]  M_AWPROT = 0, S_AWSIZE, S_AWPROT;
    logic [31:0] M_WDATA = 0, S_AWADDR, S_WDATA;
    logic M_AWREADY, M_WREADY, M_BVALID, S_AWLOCK, S_AWVALID, S_AWREADY, S_WLAST, S_WVALID;
    logic S_WREADY, S_BVALID, S_BREADY, LAST_ERROR, RESP_ERROR, ORPHAN_RESP;
    logic [3:0] S_AWID, S_AWREGION, S_AWCACHE, S_AWQOS, S_WSTRB, S_BID, PENDING_WRITES;
    logic [7:0] S_AWLEN;
    logic [1:0] S_AWBURST, S_BRESP;
    logic stall = 0, hold_b = 0, err = 0, orphan = 0;
    int fails = 0, num_checks = 0;

    wds_shim wds_shim_i (.CLK(CLK), .RESETN(RESETN), .M_AWADDR(M_AWADDR), .M_AWPROT(M_AWPROT),
        .M_AWVALID(M_AWVALID), .M_AWREADY(M_AWREADY), .M_WDATA(M_WDATA), .M_WLAST(M_WLAST),
        .M_WVALID(M_WVALID), .M_WREADY(M_WREADY), .M_BVALID(M_BVALID), .M_BREADY(M_BREADY),
        .S_AWID(S_AWID), .S_AWADDR(S_AWADDR), .S_AWREGION(S_AWREGION), .S_AWLEN(S_AWLEN),
        .S_AWSIZE(S_AWSIZE), .S_AWBURST(S_AWBURST), .S_AWLOCK(S_AWLOCK), .S_AWCACHE(S_AWCACHE),
        .S_AWPROT(S_AWPROT), .S_AWQOS(S_AWQOS), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY),
        .S_WDATA(S_WDATA), .S_WSTRB(S_WSTRB), .S_WLAST(S_WLAST), .S_WVALID(S_WVALID),
        .S_WREADY(S_WREADY), .S_BID(S_BID), .S_BRESP(S_BRESP), .S_BVALID(S_BVALID),
        .S_BREADY(S_BREADY), .LAST_ERROR(LAST_ERROR), .RESP_ERROR(RESP_ERROR),
        .ORPHAN_RESP(ORPHAN_RESP), .PENDING_WRITES(PENDING_WRITES));
    wds_slave_model wds_slave_model_i (.clk(CLK), .resetn(RESETN), .awvalid(S_AWVALID),
        .awready(S_AWREADY), .wvalid(S_WVALID), .wready(S_WREADY), .bid(S_BID),
        .bresp(S_BRESP), .bvalid(S_BVALID), .bready(S_BREADY), .stall(stall),
        .hold_b(hold_b), .err(err), .orphan(orphan));

    // Clock at 100 MHz
    always #5 CLK = ~CLK;

    // Verdict; both counters printed first
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Value compare; four-state so unknowns never match
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Address request held until ready is sampled high
    task automatic aw(logic [23:0] a, logic [2:0] p);
        M_AWADDR <= a;
        M_AWPROT <= p;
        M_AWVALID <= 1;
        for (int i = 0; i < 60; i++) begin
            @(posedge CLK);
            if (M_AWREADY === 1'b1) break;
            if (i == 59) chk("aw_timeout", 0, 1);
        end
        chk("s_awaddr", {8'h00, a}, S_AWADDR);
        chk("s_awprot", p, S_AWPROT);
        M_AWVALID <= 0;
    endtask

    // Single data beat; strobes must show all lanes
    task automatic wbeat(logic [31:0] d, logic last);
        M_WDATA <= d;
        M_WLAST <= last;
        M_WVALID <= 1;
        for (int i = 0; i < 60; i++) begin
            @(posedge CLK);
            if (M_WREADY === 1'b1) break;
            if (i == 59) chk("w_timeout", 0, 1);
        end
        chk("s_wvalid", 1, S_WVALID);
        chk("s_wdata", d, S_WDATA);
        chk("s_wlast", last, S_WLAST);
        chk("s_wstrb", 4'hf, S_WSTRB);
        M_WVALID <= 0;
    endtask

    // Defaulted slave inputs are constants from the first cycle
    task automatic t_defaults;
        chk("awid", 4'h0, S_AWID);
        chk("awregion_qos", 8'h00, {S_AWREGION, S_AWQOS});
        chk("awlen", 8'h00, S_AWLEN);
        chk("awsize", 3'h2, S_AWSIZE);
        chk("awburst", 2'h1, S_AWBURST);
        chk("awlock", 1'b0, S_AWLOCK);
        chk("awcache", 4'h0, S_AWCACHE);
    endtask

    // Slave stall passes straight back; the response then waits on the master
    task automatic t_write;
        stall <= 1;
        M_AWADDR <= 24'hab_cdef;
        M_AWPROT <= 3'h5;
        M_AWVALID <= 1;
        M_BREADY <= 0;
        repeat (3) @(posedge CLK);
        chk("stall_awready", 0, M_AWREADY);
        chk("stall_awvalid", 1, S_AWVALID);
        stall <= 0;
        aw(24'hab_cdef, 3'h5);
        @(posedge CLK);
        #1 chk("pending_one", 1, PENDING_WRITES);
        @(posedge CLK);
        wbeat(32'h1234_5678, 1);
        repeat (4) @(posedge CLK);
        #1 chk("b_waits", 1, M_BVALID);
        chk("s_bready", 0, S_BREADY);
        chk("pending_held", 1, PENDING_WRITES);
        @(posedge CLK);
        M_BREADY <= 1;
        repeat (3) @(posedge CLK);
        #1 chk("pending_zero", 0, PENDING_WRITES);
        chk("flags_clean", 0, {LAST_ERROR, RESP_ERROR, ORPHAN_RESP});
        @(posedge CLK);
    endtask

    // Fifteen writes owed: a further address waits, never wraps
    task automatic t_fill;
        hold_b <= 1;
        for (int i = 0; i < 15; i++) begin
            aw(24'(i * 4), 3'h0);
            wbeat(32'(i), 1);
        end
        M_AWADDR <= 24'hff_fffc;
        M_AWPROT <= 3'h7;
        M_AWVALID <= 1;
        repeat (3) @(posedge CLK);
        chk("pend_max", 15, PENDING_WRITES);
        chk("full_awready", 0, M_AWREADY);
        chk("full_awvalid", 0, S_AWVALID);
        hold_b <= 0;
        aw(24'hff_fffc, 3'h7);
        wbeat(32'hffff_ffff, 1);
        repeat (60) @(posedge CLK);
        #1 chk("drained", 0, PENDING_WRITES);
        @(posedge CLK);
    endtask

    // Short last marker, error code, then a response with none owed
    task automatic t_faults;
        wbeat(32'h0000_0001, 0);
        repeat (2) @(posedge CLK);
        #1 chk("last_error", 1, LAST_ERROR);
        @(posedge CLK);
        err <= 1;
        aw(24'h00_0010, 3'h1);
        wbeat(32'h0000_0002, 1);
        repeat (6) @(posedge CLK);
        #1 chk("resp_error", 1, RESP_ERROR);
        chk("no_orphan", 0, ORPHAN_RESP);
        @(posedge CLK);
        err <= 0;
        orphan <= 1;
        @(posedge CLK);
        orphan <= 0;
        repeat (5) @(posedge CLK);
        #1 chk("orphan", 1, ORPHAN_RESP);
        chk("pend_floor", 0, PENDING_WRITES);
        @(posedge CLK);
    endtask

    // Mid-run reset clears the sticky flags; a clean write follows
    task automatic t_reset;
        RESETN <= 0;
        repeat (2) @(posedge CLK);
        #1 chk("rst_flags", 0, {LAST_ERROR, RESP_ERROR, ORPHAN_RESP});
        @(posedge CLK);
        RESETN <= 1;
        @(posedge CLK);
        aw(24'h00_0020, 3'h2);
        wbeat(32'h0000_0003, 1);
        repeat (6) @(posedge CLK);
        #1 chk("rst_clean", 0, {LAST_ERROR, RESP_ERROR, ORPHAN_RESP, PENDING_WRITES});
    endtask

    // Hang guard well beyond the expected run
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge CLK);
        RESETN <= 1;
        @(posedge CLK);
        t_defaults();
        t_write();
        t_fill();
        t_faults();
        t_reset();
        end_sim();
    end
endmodule
